// File: rtl/csp_status_regs.sv
/*
 * Register bank for status-pin monitor options, divider sync, power-down
 * and the self-clearing update strobe. Writes land in buffer registers and
 * reach the active set on the update. Assumes the serial-port clock and
 * all pin-level sources arrive raw from outside the clock domain, so each
 * passes two flip-flops here.
 */
// Behaviour
// - Select codes up to 010111 route monitor sources; higher codes are reserved.
// - Options bit 4 puts nonvolatile-transfer status on the first status pin.
// - Options bit 3 divides the second status pin by four.
// - Options bit 2 divides the first status pin by four; zero means none.
// - Options bit 0 holds all output dividers in sync like the sync pin.
// - Power-down bits 2,1,0: first loop, second loop, distribution; default one.
// - Update bit copies buffers into active registers at next serial clock rise.
// - Update bit clears itself after the transfer.
// - Nonvolatile-transfer status reads one while a transfer is running.
`timescale 1ns/1ps
`default_nettype none
module csp_status_regs (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [csp_pkg::ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regReadData,
	input wire logic serialClockPin,
	input wire logic nvTransferBusyPin,
	input wire logic syncPin_n,
	input wire logic [csp_pkg::MONITOR_SRC_W-1:0] monitorSources,
	output logic statusPinFirst,
	output logic statusPinSecond,
	output logic dividerSyncHold,
	output csp_pkg::csp_power_s powerDown
);
	import csp_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic sclkMeta, sclkSync;
	logic nvMeta, nvSync;
	logic syncMeta, syncSync;
	logic [MONITOR_SRC_W-1:0] srcMeta, srcSync;
	logic sclkPrev;
	logic sclkRise;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sclkMeta <= 1'b0;
			sclkSync <= 1'b0;
			nvMeta <= 1'b0;
			nvSync <= 1'b0;
			syncMeta <= 1'b1;
			syncSync <= 1'b1;
			srcMeta <= '0;
			srcSync <= '0;
			sclkPrev <= 1'b0;
		end else begin
			sclkMeta <= serialClockPin;
			sclkSync <= sclkMeta;
			nvMeta <= nvTransferBusyPin;
			nvSync <= nvMeta;
			syncMeta <= syncPin_n;
			syncSync <= syncMeta;
			srcMeta <= monitorSources;
			srcSync <= srcMeta;
			sclkPrev <= sclkSync;
		end
	end

	assign sclkRise = sclkSync & ~sclkPrev;

	// ----------------------------------------
	// Buffer and active registers
	// ----------------------------------------
	csp_bank_s buffered;
	csp_bank_s active;
	logic updatePending;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			buffered.selFirst <= RST_MONITOR_SELECT;
			buffered.selSecond <= RST_MONITOR_SELECT;
			buffered.pinOptions <= RST_STATUS_PIN_OPTIONS;
			buffered.powerDown <= RST_POWER_DOWN_CONTROL;
		end else if (regWrite) begin
			case (regAddr)
				OFF_MONITOR_SELECT_FIRST: buffered.selFirst <= regWriteData[5:0];
				OFF_MONITOR_SELECT_SECOND: buffered.selSecond <= regWriteData[5:0];
				OFF_STATUS_PIN_OPTIONS: begin
					buffered.pinOptions <= regWriteData & MASK_STATUS_PIN_OPTIONS;
				end
				OFF_POWER_DOWN_CONTROL: begin
					buffered.powerDown <= regWriteData & MASK_POWER_DOWN_CONTROL;
				end
				default: ;
			endcase
		end
	end

	// A strobe written in the same cycle as a serial rise still waits for the next rise
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			updatePending <= 1'b0;
		end else if (regWrite && regAddr == OFF_UPDATE_ALL_STROBE
				&& regWriteData[BIT_UPDATE]) begin
			updatePending <= 1'b1;
		end else if (sclkRise) begin
			updatePending <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			active.selFirst <= RST_MONITOR_SELECT;
			active.selSecond <= RST_MONITOR_SELECT;
			active.pinOptions <= RST_STATUS_PIN_OPTIONS;
			active.powerDown <= RST_POWER_DOWN_CONTROL;
		end else if (updatePending && sclkRise) begin
			active <= buffered;
		end
	end

	// ----------------------------------------
	// Monitor select and divide-by-4
	// ----------------------------------------
	function automatic logic pickSource(input logic [5:0] sel,
			input logic [MONITOR_SRC_W-1:0] src);
		logic picked;
		picked = 1'b0;
		if (sel <= SEL_LAST_VALID) begin
			picked = src[sel[4:0]];
		end
		return picked;
	endfunction

	logic rawFirst, rawSecond;
	logic divCountFirst, divCountSecond;
	logic rawFirstPrev, rawSecondPrev;
	logic divFirst, divSecond;

	assign rawFirst = pickSource(active.selFirst, srcSync);
	assign rawSecond = pickSource(active.selSecond, srcSync);

	// Divide-by-4: toggle output every second rising edge of the source
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rawFirstPrev <= 1'b0;
			rawSecondPrev <= 1'b0;
			divCountFirst <= 1'b0;
			divCountSecond <= 1'b0;
			divFirst <= 1'b0;
			divSecond <= 1'b0;
		end else begin
			rawFirstPrev <= rawFirst;
			rawSecondPrev <= rawSecond;
			if (rawFirst && !rawFirstPrev) begin
				divCountFirst <= ~divCountFirst;
				if (divCountFirst) begin
					divFirst <= ~divFirst;
				end
			end
			if (rawSecond && !rawSecondPrev) begin
				divCountSecond <= ~divCountSecond;
				if (divCountSecond) begin
					divSecond <= ~divSecond;
				end
			end
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	// Static selections divided would freeze the pin; host keeps divider off there
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			statusPinFirst <= 1'b0;
			statusPinSecond <= 1'b0;
		end else begin
			if (active.pinOptions[BIT_NV_ON_FIRST]) begin
				statusPinFirst <= nvSync;
			end else if (active.pinOptions[BIT_FIRST_DIV4]) begin
				statusPinFirst <= divFirst;
			end else begin
				statusPinFirst <= rawFirst;
			end
			statusPinSecond <= active.pinOptions[BIT_SECOND_DIV4] ? divSecond : rawSecond;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dividerSyncHold <= 1'b0;
			powerDown <= '{firstLoop: 1'b1, secondLoop: 1'b1, distribution: 1'b1};
		end else begin
			dividerSyncHold <= active.pinOptions[BIT_SYNC_HOLD] | ~syncSync;
			powerDown.firstLoop <= active.powerDown[BIT_PD_FIRST_LOOP];
			powerDown.secondLoop <= active.powerDown[BIT_PD_SECOND_LOOP];
			powerDown.distribution <= active.powerDown[BIT_PD_DISTRIBUTION];
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Reads show the buffered set, the value the next update will apply
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			regReadData <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				OFF_MONITOR_SELECT_FIRST: regReadData <= {2'h0, buffered.selFirst};
				OFF_MONITOR_SELECT_SECOND: regReadData <= {2'h0, buffered.selSecond};
				OFF_STATUS_PIN_OPTIONS: regReadData <= buffered.pinOptions;
				OFF_POWER_DOWN_CONTROL: regReadData <= buffered.powerDown;
				OFF_UPDATE_ALL_STROBE: regReadData <= {7'h00, updatePending};
				OFF_NV_TRANSFER_STATUS: regReadData <= {7'h00, nvSync};
				default: regReadData <= 8'h00;
			endcase
		end else begin
			regReadData <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// File: rtl/csp_pkg.sv
/*
 * Package for the status-pin, power-down and update register bank:
 * offsets, field positions, reset values and carrier structs.
 * Assumes a single 10 MHz clock and a plain strobe register port.
 */
package csp_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_STATUS_PIN_OPTIONS = 12'h0232;
	localparam logic [11:0] OFF_POWER_DOWN_CONTROL = 12'h0233;
	localparam logic [11:0] OFF_UPDATE_ALL_STROBE = 12'h0234;
	localparam logic [11:0] OFF_MONITOR_SELECT_FIRST = 12'h0230;
	localparam logic [11:0] OFF_MONITOR_SELECT_SECOND = 12'h0231;
	localparam logic [11:0] OFF_NV_TRANSFER_STATUS = 12'h0b00;
	// Status pin options fields
	localparam int BIT_SYNC_HOLD = 0;
	localparam int BIT_FIRST_DIV4 = 2;
	localparam int BIT_SECOND_DIV4 = 3;
	localparam int BIT_NV_ON_FIRST = 4;
	localparam logic [7:0] MASK_STATUS_PIN_OPTIONS = 8'h1d;
	// Power-down fields
	localparam int BIT_PD_DISTRIBUTION = 0;
	localparam int BIT_PD_SECOND_LOOP = 1;
	localparam int BIT_PD_FIRST_LOOP = 2;
	localparam logic [7:0] MASK_POWER_DOWN_CONTROL = 8'h07;
	localparam int BIT_UPDATE = 0;
	// Monitor select
	localparam logic [5:0] MASK_MONITOR_SELECT = 6'h3f;
	localparam logic [5:0] SEL_LAST_VALID = 6'h17;
	localparam logic [5:0] SEL_STATIC_LAST = 6'h0f;
	localparam int MONITOR_SRC_W = 24;
	// Reset values
	localparam logic [7:0] RST_STATUS_PIN_OPTIONS = 8'h00;
	localparam logic [7:0] RST_POWER_DOWN_CONTROL = 8'h07;
	localparam logic [5:0] RST_MONITOR_SELECT = 6'h00;

	typedef struct packed {
		logic [5:0] selFirst;
		logic [5:0] selSecond;
		logic [7:0] pinOptions;
		logic [7:0] powerDown;
	} csp_bank_s;

	typedef struct packed {
		logic firstLoop;
		logic secondLoop;
		logic distribution;
	} csp_power_s;
endpackage

// File: tb/csp_host.sv
/* Host model on the register port: bus cycles and serial clock frames.
   Assumes a bank that never stalls and answers a read one cycle later. */
`timescale 1ns/1ps
`default_nettype none
module csp_host (
	input wire logic clock,
	input wire logic [7:0] regReadData,
	output logic [csp_pkg::ADDR_W-1:0] regAddr = 12'h000,
	output logic [7:0] regWriteData = 8'h00,
	output logic regWrite = 1'b0,
	output logic regRead = 1'b0,
	output logic serialClockPin = 1'b0
);
	import csp_pkg::*;
	// Idle bus shows inverted values, never a stale copy
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		@(posedge clock);
		regAddr <= a;
		regWriteData <= v;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		regAddr <= ~a;
		regWriteData <= ~v;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		regAddr <= ~a;
		// Answer stands until the next edge; take it there
		@(posedge clock);
		v = regReadData;
	endtask
	// Serial clock only moves inside a frame
	task automatic sclk();
		@(posedge clock) serialClockPin <= 1'b1;
		repeat (2) @(posedge clock);
		serialClockPin <= 1'b0;
	endtask
	task automatic commit();
		wr(OFF_UPDATE_ALL_STROBE, 8'h01);
		sclk();
		repeat (8) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// File: tb/csp_status_regs_chk.sv
/* Port checker for the status register bank, bound to its top module.
   Assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module csp_status_regs_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [csp_pkg::ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regReadData,
	input wire logic serialClockPin,
	input wire logic nvTransferBusyPin,
	input wire logic syncPin_n,
	input wire logic [csp_pkg::MONITOR_SRC_W-1:0] monitorSources,
	input wire logic statusPinFirst,
	input wire logic statusPinSecond,
	input wire logic dividerSyncHold,
	input wire csp_pkg::csp_power_s powerDown
);
	import csp_pkg::*;
	logic [3:0] sinceSclk;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Saturating age of the last serial clock high sample
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) sinceSclk <= 4'hf;
		else if (serialClockPin) sinceSclk <= 4'h0;
		else if (sinceSclk != 4'hf) sinceSclk <= sinceSclk + 4'h1;
	end
	// ----------
	// Assertions
	// ----------
	chk_read_idle: assert property (!$past(regRead) |-> regReadData == 8'h00)
		else $error("read data outside a read answer");
	chk_unmapped_read: assert property (regRead && !(regAddr inside {[12'h230:12'h234],
		12'hb00}) |=> regReadData == 8'h00) else $error("unmapped read not zero");
	chk_pd_reset: assert property (!$past(reset_n) |-> powerDown == 3'h7)
		else $error("power-down not all set after reset");
	chk_pd_update: assert property ($changed(powerDown) |-> sinceSclk <= 4'h6)
		else $error("power-down moved without an update edge");
	chk_sync_pin_hold: assert property (!syncPin_n [*6] |-> dividerSyncHold)
		else $error("sync pin low but dividers not held");
	chk_nv_status_read: assert property ($stable(nvTransferBusyPin) [*4] ##0
		(regRead && regAddr == 12'hb00) |=> regReadData == {7'h00, $past(nvTransferBusyPin)})
		else $error("transfer status read wrong");
	chk_opt_reserved: assert property (regRead && regAddr == 12'h232 |=>
		(regReadData & 8'he2) == 8'h00) else $error("options reserved bits set");
	chk_pd_reserved: assert property (regRead && regAddr == 12'h233 |=>
		regReadData[7:3] == 5'h00) else $error("power-down reserved bits set");
endmodule
bind csp_status_regs csp_status_regs_chk u_chk (.clock(clock), .reset_n(reset_n),
	.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
	.regReadData(regReadData), .serialClockPin(serialClockPin),
	.nvTransferBusyPin(nvTransferBusyPin), .syncPin_n(syncPin_n),
	.monitorSources(monitorSources), .statusPinFirst(statusPinFirst),
	.statusPinSecond(statusPinSecond), .dividerSyncHold(dividerSyncHold),
	.powerDown(powerDown));
`default_nettype wire

// File: tb/csp_status_regs_bench.sv
/* Self-checking bench for the status register bank with a host model.
   Assumes csp_pkg and csp_host are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module csp_status_regs_bench;
	import csp_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic nvBusy = 1'b0;
	logic syncPin_n = 1'b1;
	logic [MONITOR_SRC_W-1:0] src = 24'h00_0000;
	logic [ADDR_W-1:0] regAddr;
	logic [7:0] wData, rData, d;
	logic regWrite, regRead, sclk, pinF, pinS, hold, pF, pS;
	csp_power_s pd;
	int nErrors = 0, compares = 0, cycles = 0, nF = 0, nS = 0;
	always #50 clock = ~clock;
	csp_host h (.clock(clock), .regReadData(rData), .regAddr(regAddr), .regWriteData(wData),
		.regWrite(regWrite), .regRead(regRead), .serialClockPin(sclk));
	csp_status_regs DUT (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
		.regWriteData(wData), .regWrite(regWrite), .regRead(regRead), .regReadData(rData),
		.serialClockPin(sclk), .nvTransferBusyPin(nvBusy), .syncPin_n(syncPin_n),
		.monitorSources(src), .statusPinFirst(pinF), .statusPinSecond(pinS),
		.dividerSyncHold(hold), .powerDown(pd));
	always @(posedge clock) begin
		cycles++;
		if (pinF !== pF) nF++;
		if (pinS !== pS) nS++;
		pF = pinF;
		pS = pinS;
		if (cycles == 20000) begin
			nErrors++;
			conclude();
		end
	end
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			nErrors++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d of %0d compares", nErrors, compares);
		if (nErrors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
		h.rd(a, d);
		check(d, e);
	endtask
	// ---------
	// Scenarios
	// ---------
	task automatic t_regs();
		check({5'h00, pd}, 8'h07);
		rdc(12'h233, 8'h07);
		rdc(12'h234, 8'h00);
		h.wr(12'h232, 8'hff);
		rdc(12'h232, 8'h1d);
		h.wr(12'h235, 8'h5a);
		rdc(12'h235, 8'h00);
		h.wr(12'h232, 8'h00);
	endtask
	task automatic t_update();
		h.wr(12'h233, 8'hfc);
		wt(8);
		check({5'h00, pd}, 8'h07);
		h.wr(12'h234, 8'h01);
		rdc(12'h234, 8'h01);
		check({5'h00, pd}, 8'h07);
		h.sclk();
		wt(8);
		check({5'h00, pd}, 8'h04);
		rdc(12'h234, 8'h00);
		h.wr(12'h233, 8'h03);
		h.commit();
		check({5'h00, pd}, 8'h03);
	endtask
	task automatic t_route();
		h.wr(12'h230, 8'h17);
		h.wr(12'h231, 8'h17);
		h.commit();
		@(posedge clock) src <= 24'h80_0000;
		wt(6);
		check({7'h00, pinF}, 8'h01);
		check({7'h00, pinS}, 8'h01);
		@(posedge clock) src <= 24'h7f_ffff;
		wt(6);
		check({7'h00, pinF}, 8'h00);
		check({7'h00, pinS}, 8'h00);
		@(posedge clock) src <= 24'hff_ffff;
		h.wr(12'h230, 8'h18);
		h.commit();
		check({7'h00, pinF}, 8'h00);
		check({7'h00, pinS}, 8'h01);
	endtask
	task automatic t_nv();
		// Selected source is high, so a low pin shows the override
		h.wr(12'h230, 8'h17);
		h.wr(12'h232, 8'h10);
		h.commit();
		@(posedge clock) nvBusy <= 1'b1;
		wt(6);
		check({7'h00, pinF}, 8'h01);
		rdc(12'hb00, 8'h01);
		@(posedge clock) nvBusy <= 1'b0;
		wt(6);
		check({7'h00, pinF}, 8'h00);
		rdc(12'hb00, 8'h00);
	endtask
	task automatic t_div();
		h.wr(12'h230, 8'h10);
		h.wr(12'h231, 8'h11);
		h.wr(12'h232, 8'h0c);
		h.commit();
		nF = 0;
		nS = 0;
		// Four rising edges on each source give two output toggles
		for (int i = 0; i < 8; i++) begin
			@(posedge clock) src <= src ^ 24'h03_0000;
			wt(6);
		end
		check(nF[7:0], 8'h02);
		check(nS[7:0], 8'h02);
	endtask
	task automatic t_sync();
		h.wr(12'h232, 8'h01);
		h.commit();
		check({7'h00, hold}, 8'h01);
		h.wr(12'h232, 8'h00);
		h.commit();
		check({7'h00, hold}, 8'h00);
		@(posedge clock) syncPin_n <= 1'b0;
		wt(8);
		check({7'h00, hold}, 8'h01);
	endtask
	task automatic t_reset();
		@(posedge clock) reset_n <= 1'b0;
		wt(3);
		reset_n <= 1'b1;
		check({5'h00, pd}, 8'h07);
		check({7'h00, hold}, 8'h00);
		rdc(12'h233, 8'h07);
		wt(4);
		check({7'h00, hold}, 8'h01);
	endtask
	initial begin
		wt(6);
		reset_n <= 1'b1;
		t_regs();
		t_update();
		t_route();
		t_nv();
		t_div();
		t_sync();
		t_reset();
		conclude();
	end
endmodule
`default_nettype wire
